// >>> hw/iemb_pkg.sv
// Package of the interrupt enable mask bank: map, reset values, carriers.
// Assumes a 32-bit classic Wishbone master with byte addresses.
package iemb_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NumWords = 4;
    localparam int WordBits = 16;
    localparam int PrioBits = 3;
    localparam int NumSrc   = 64;

    // ------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] EnableBase = 8'h00;
    localparam logic [7:0] FlagBase   = 8'h10;
    localparam logic [7:0] PrioBase   = 8'h20;
    localparam logic [7:0] MapEnd     = 8'h40;

    // ------------------------------------------------------------
    // Implemented bit positions of each mask word
    // ------------------------------------------------------------
    localparam logic [15:0] ImplMask0 = 16'h7FFF;
    localparam logic [15:0] ImplMask1 = 16'hFFFB;
    localparam logic [15:0] ImplMask2 = 16'hDFFF;
    localparam logic [15:0] ImplMask3 = 16'h39FF;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] EnableReset = 16'h0000;
    localparam logic [15:0] FlagReset   = 16'h0000;
    localparam logic [2:0]  PrioReset   = 3'h4;
    localparam logic [2:0]  PrioOff     = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } iemb_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } iemb_wb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] prio;
        logic [5:0] vec;
    } iemb_irq_t;

    // Byte lane mask of the low half word
    function automatic logic [15:0] laneMask16(input logic [1:0] sel);
        laneMask16 = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

endpackage

// >>> hw/iemb_mask_word.sv
// One mask word: 16 enable bits, 16 flags and 16 priority fields.
// Assumes strobes are single-cycle; this module gates them with the clock enable.
`timescale 1ns/10ps
module iemb_mask_word
    import iemb_pkg::*;
#(
    parameter logic [15:0] ImplMask = 16'hFFFF
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Write strobes
    input  wire logic        wrEnable,
    input  wire logic        wrFlag,
    input  wire logic        wrPrioLo,
    input  wire logic        wrPrioHi,
    input  wire logic [31:0] wrData,
    input  wire logic [3:0]  wrSel,
    // Sources and state
    input  wire logic [15:0] srcReq,
    output logic      [15:0] enQ,
    output logic      [15:0] flagQ,
    output logic      [47:0] prioQ,
    output logic      [15:0] pend
);

    logic [15:0]       en_q;
    logic [15:0]       en_d;
    logic [15:0]       flag_q;
    logic [15:0]       flag_d;
    logic [15:0][2:0]  prio_q;
    logic [15:0][2:0]  prio_d;
    logic [15:0]       prioLive;
    wire  [15:0]       laneMask = laneMask16(wrSel[1:0]);
    wire  [15:0]       flagClr  = wrFlag ? (wrData[15:0] & laneMask)
                                         : 16'h0000;

    assign en_d = ((en_q & ~laneMask) | (wrData[15:0] & laneMask))
                  & ImplMask;

    assign flag_d = ((flag_q & ~flagClr) | srcReq) & ImplMask;

    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            prio_d[i] = prio_q[i];
            if (((i < 8) ? wrPrioLo : wrPrioHi) && wrSel[(i % 8) / 2])
            begin
                prio_d[i] = wrData[4 * (i % 8) +: 3];
            end
            prioLive[i] = (prio_q[i] != PrioOff);
            prioQ[3 * i +: 3] = ImplMask[i] ? prio_q[i] : PrioOff;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            en_q   <= EnableReset;
            flag_q <= FlagReset;
            prio_q <= {16{PrioReset}};
        end
        else if (ce)
        begin
            if (wrEnable)
            begin
                en_q <= en_d;
            end
            flag_q <= flag_d;
            prio_q <= prio_d;
        end
    end

    assign enQ   = en_q;
    assign flagQ = flag_q;
    assign pend  = flag_q & en_q & prioLive & ImplMask;

endmodule

// >>> hw/iemb_enable_bank.sv
// Top of the interrupt enable mask bank: Wishbone slave, four mask
// words with flags and priorities, and priority resolution.
// Assumes one clock, synchronous source requests held for >= 1 cycle.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module iemb_enable_bank
    import iemb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         ce,
    // Register bus
    input  wire iemb_wb_req_t wbReq,
    output iemb_wb_rsp_t      wbRsp,
    // Peripheral requests, index word * 16 + bit
    input  wire logic [63:0]  srcReq,
    // CPU interrupt path
    output logic      [63:0]  pendReq,
    output iemb_irq_t         irqOut
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic          ack_q;
    logic [31:0]   rdat_q;
    logic [31:0]   rdat_d;

    wire        busReq   = wbReq.cyc & wbReq.stb;
    wire        busFirst = busReq & ~ack_q;
    // Writes land on the edge that the master samples ack
    wire        busWrite = busReq & wbReq.we & ack_q;
    wire        inMap    = (wbReq.adr < MapEnd);
    wire        isEnable = inMap && (wbReq.adr[7:4] == EnableBase[7:4]);
    wire        isFlag   = inMap && (wbReq.adr[7:4] == FlagBase[7:4]);
    wire        isPrio   = inMap && (wbReq.adr[7:5] == PrioBase[7:5]);
    wire [1:0]  flatWord = wbReq.adr[3:2];
    wire [1:0]  prioWord = wbReq.adr[4:3];
    wire        prioHalf = wbReq.adr[2];

    // ------------------------------------------------------------
    // Mask words
    // ------------------------------------------------------------
    localparam logic [15:0] ImplMasks [NumWords] =
        '{ImplMask0, ImplMask1, ImplMask2, ImplMask3};

    logic [NumWords-1:0][15:0] enQ;
    logic [NumWords-1:0][15:0] flagQ;
    logic [NumWords-1:0][47:0] prioQ;
    logic [NumWords-1:0][15:0] pend;
    logic [NumWords-1:0]       wrEnable;
    logic [NumWords-1:0]       wrFlag;
    logic [NumWords-1:0]       wrPrioLo;
    logic [NumWords-1:0]       wrPrioHi;

    // Bit positions per word:
    // w0 [2] cmp1, [1] cap1, [0] extpin0
    // w1 [15:8] uart2 tx/rx, extpin2, tmr5, tmr4, cmp4, cmp3, dma2
    // w1 [7:3] cap8, cap7, conv2, extpin1, pin change; [2] none
    // w1 [1] i2c_a master, [0] i2c_a slave
    // w2 [15:14] tmr6, dma4; [13] none; [12:9] cmp8..5; [8] cap6
    // w2 [7:0] cap5..3, dma3, can_a event/rx, spi_b event/error
    // w3 [15:14] none; [13] dma5; [12:11] codec event/error
    // w3 [10:9] none; [8] can_b event
    // w3 [7:0] can_b rx, extpin4, extpin3, tmr9, tmr8,
    //          i2c_b master, i2c_b slave, tmr7
    genvar w;
    generate
        for (w = 0; w < NumWords; w++)
        begin : gWord
            assign wrEnable[w] = busWrite & isEnable &
                                 (flatWord == w[1:0]);
            assign wrFlag[w]   = busWrite & isFlag &
                                 (flatWord == w[1:0]);
            assign wrPrioLo[w] = busWrite & isPrio & ~prioHalf &
                                 (prioWord == w[1:0]);
            assign wrPrioHi[w] = busWrite & isPrio & prioHalf &
                                 (prioWord == w[1:0]);

            iemb_mask_word #(
                .ImplMask (ImplMasks[w])
            ) uWord (
                .clock    (clock),
                .rstn     (rstn),
                .ce       (ce),
                .wrEnable (wrEnable[w]),
                .wrFlag   (wrFlag[w]),
                .wrPrioLo (wrPrioLo[w]),
                .wrPrioHi (wrPrioHi[w]),
                .wrData   (wbReq.dat),
                .wrSel    (wbReq.sel),
                .srcReq   (srcReq[16 * w +: 16]),
                .enQ      (enQ[w]),
                .flagQ    (flagQ[w]),
                .prioQ    (prioQ[w]),
                .pend     (pend[w])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Spreads eight 3-bit fields into 4-bit lanes
    function automatic logic [31:0] prioWordRead(
        input logic [23:0] fields
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int j = 0; j < 8; j++)
        begin
            r[4 * j +: 3] = fields[3 * j +: 3];
        end
        prioWordRead = r;
    endfunction

    wire [47:0] prioSel   = prioQ[prioWord];
    wire [23:0] prioField = prioHalf ? prioSel[47:24] : prioSel[23:0];

    always_comb
    begin
        rdat_d = 32'h0000_0000;
        if (isEnable)
        begin
            rdat_d = {16'h0000, enQ[flatWord]};
        end
        else if (isFlag)
        begin
            rdat_d = {16'h0000, flagQ[flatWord]};
        end
        else if (isPrio)
        begin
            rdat_d = prioWordRead(prioField);
        end
    end

    // One wait state: ack one cycle after the request, then low
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_q <= busFirst;
            if (busFirst)
            begin
                rdat_q <= rdat_d;
            end
        end
    end

    assign wbRsp.ack = ack_q;
    assign wbRsp.dat = rdat_q;

    // ------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------
    logic [63:0]  pendFlat;
    logic [191:0] prioFlat;
    iemb_irq_t    irq_q;
    iemb_irq_t    irq_d;

    always_comb
    begin
        for (int k = 0; k < NumWords; k++)
        begin
            pendFlat[16 * k +: 16]  = pend[k];
            prioFlat[48 * k +: 48]  = prioQ[k];
        end
    end

    // Highest field wins; ties go to the lowest source index
    function automatic iemb_irq_t pickWinner(
        input logic [63:0]  req,
        input logic [191:0] prio
    );
        iemb_irq_t best;
        best = '0;
        for (int s = 0; s < NumSrc; s++)
        begin
            if (req[s] && (!best.valid ||
                prio[3 * s +: 3] > best.prio))
            begin
                best.valid = 1'b1;
                best.prio  = prio[3 * s +: 3];
                best.vec   = s[5:0];
            end
        end
        pickWinner = best;
    endfunction

    assign irq_d = pickWinner(pendFlat, prioFlat);

    // Registered so the CPU sees a glitch-free request
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            irq_q <= '0;
        end
        else if (ce)
        begin
            irq_q <= irq_d;
        end
    end

    assign pendReq = pendFlat;
    assign irqOut  = irq_q;

endmodule

// >>> verif/iemb_enable_bank_properties.sv
// Checker of the enable bank, bound to the top ports.
// Assumes one clock domain and the bus timing of the hand-over.
`timescale 1ns/10ps
module iemb_chk
    import iemb_pkg::*;
(
    input wire logic         clock,
    input wire logic         rstn,
    input wire logic         ce,
    input wire iemb_wb_req_t wbReq,
    input wire iemb_wb_rsp_t wbRsp,
    input wire logic [63:0]  srcReq,
    input wire logic [63:0]  pendReq,
    input wire iemb_irq_t    irqOut
);
    localparam logic [63:0] Impl = {ImplMask3, ImplMask2,
                                    ImplMask1, ImplMask0};
    wire logic        rdAck = wbRsp.ack && !wbReq.we;
    wire logic [15:0] implW = Impl[{wbReq.adr[3:2], 4'h0} +: 16];

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    a_ack_next:
        assert property (ce && wbReq.cyc && wbReq.stb && !wbRsp.ack
            |=> wbRsp.ack) else $error("ack missing");
    a_ack_single:
        assert property (wbRsp.ack && ce |=> !wbRsp.ack)
            else $error("ack too long");
    a_ack_cause:
        assert property (ce && !(wbReq.cyc && wbReq.stb) |=> !wbRsp.ack)
            else $error("ack without request");
    a_unimpl_pend:
        assert property ((pendReq & ~Impl) == 64'h0)
            else $error("pending on unused bit");
    a_pend_rise_cause:
        assert property (!$past(wbRsp.ack) |->
            ((pendReq & ~$past(pendReq) & ~$past(srcReq)) == 64'h0))
            else $error("pending rose without cause");
    a_irq_valid:
        assert property (ce |=> irqOut.valid == (|$past(pendReq)))
            else $error("irq valid wrong");
    a_irq_vec_pend:
        assert property (irqOut.valid |->
            ((($past(pendReq) >> irqOut.vec) & 64'h1) != 64'h0))
            else $error("irq vector not pending");
    a_ce_freeze:
        assert property (!ce |=> $stable(wbRsp) && $stable(pendReq)
            && $stable(irqOut)) else $error("state moved with ce low");
    a_rd_unused_zero:
        assert property (rdAck && wbReq.adr < 8'h20 |->
            (wbRsp.dat & ~{16'h0, implW}) == 32'h0)
            else $error("unused bit read nonzero");
    a_unmapped_zero:
        assert property (rdAck && wbReq.adr >= MapEnd |->
            wbRsp.dat == 32'h0) else $error("unmapped read nonzero");
endmodule

bind iemb_enable_bank iemb_chk u_chk (.clock(clock), .rstn(rstn),
    .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp), .srcReq(srcReq),
    .pendReq(pendReq), .irqOut(irqOut));

// >>> verif/iemb_periph_model.sv
// Peripheral side: raises source requests as one-cycle events.
// Assumes the bench pulses fire for one clock.
`timescale 1ns/10ps
module iemb_periph_model (
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [63:0] fireMask,
    output logic      [63:0] srcReq
);
    initial srcReq = 64'h0;
    // Event pulses, so flags must latch them
    always @(posedge clock)
        srcReq <= fire ? fireMask : 64'h0;
endmodule

// >>> verif/iemb_enable_bank_tb.sv
// Bench of the enable bank: Wishbone tasks and source pulses.
// Assumes the bound checker and the peripheral model.
`timescale 1ns/10ps
module iemb_enable_bank_tb
    import iemb_pkg::*;
;
    localparam logic [63:0] Impl = {ImplMask3, ImplMask2,
                                    ImplMask1, ImplMask0};
    logic         clock = 1'b0;
    logic         rstn = 1'b0;
    logic         ce = 1'b1;
    logic         fire = 1'b0;
    logic [63:0]  fireMask = 64'h0;
    iemb_wb_req_t wbReq = '0;
    iemb_wb_rsp_t wbRsp;
    logic [63:0]  srcReq;
    logic [63:0]  pendReq;
    iemb_irq_t    irqOut;
    logic [31:0]  rd;
    int           fails = 0;
    int           num_checks = 0;
    int           cycles = 0;

    always #5 clock = ~clock;

    iemb_enable_bank u_iemb_enable_bank (.clock(clock), .rstn(rstn),
        .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp), .srcReq(srcReq),
        .pendReq(pendReq), .irqOut(irqOut));
    iemb_periph_model u_iemb_periph_model (.clock(clock), .fire(fire),
        .fireMask(fireMask), .srcReq(srcReq));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Whole run needs about 490 cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic check(input string nm, input logic [63:0] seen,
                         input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then release
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [3:0] sel, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        wbReq <= {2'b11, we, adr, sel, wd};
        @(posedge clock);
        while (wbRsp.ack !== 1'b1 && n < 10)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 10)
            fails++;
        rd = wbRsp.dat;
        wbReq <= '0;
    endtask

    task automatic rdChk(input string nm, input logic [7:0] adr,
                         input logic [31:0] exp);
        xfer(1'b0, adr, 4'hF, 32'h0);
        check(nm, {32'h0, rd}, {32'h0, exp});
    endtask

    task automatic pulse(input logic [63:0] m);
        @(posedge clock);
        fire <= 1'b1;
        fireMask <= m;
        @(posedge clock);
        fire <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic pendChk(input string nm, input logic [63:0] exp);
        @(negedge clock);
        check(nm, pendReq, exp);
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        for (int w = 0; w < 4; w++)
        begin
            rdChk("enable reset", 8'(4 * w), 32'h0);
            rdChk("flag reset", 8'(16 + 4 * w), 32'h0);
            xfer(1'b1, 8'(4 * w), 4'hF, 32'hFFFF_FFFF);
            rdChk("enable rw", 8'(4 * w), {16'h0, Impl[16 * w +: 16]});
            xfer(1'b1, 8'(4 * w), 4'hF, 32'h0);
        end
        rdChk("prio reset", 8'h20, 32'h4444_4444);
        xfer(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
        rdChk("unmapped", 8'h40, 32'h0);
        // Flags latch while masked, nothing passes
        pulse({64{1'b1}});
        pendChk("masked", 64'h0);
        rdChk("flag set", 8'h10, {16'h0, ImplMask0});
        for (int i = 0; i < 64; i++)
        begin
            xfer(1'b1, 8'(4 * (i / 16)), 4'hF, 32'h1 << (i % 16));
            pendChk("gate", Impl[i] ? 64'h1 << i : 64'h0);
            xfer(1'b1, 8'(4 * (i / 16)), 4'hF, 32'h0);
        end
        xfer(1'b1, 8'h00, 4'hF, 32'h1);
        xfer(1'b1, 8'h20, 4'h1, 32'h0);
        pendChk("prio off", 64'h0);
        xfer(1'b1, 8'h20, 4'h1, 32'h7);
        pendChk("prio on", 64'h1);
        @(negedge clock);
        check("irq", {54'h0, irqOut}, {54'h0, 1'b1, 3'h7, 6'h0});
        // Events while the clock enable is low are not seen
        xfer(1'b1, 8'h10, 4'hF, 32'hFFFF);
        @(posedge clock);
        ce <= 1'b0;
        pulse({64{1'b1}});
        ce <= 1'b1;
        rdChk("flag frozen", 8'h10, 32'h0);
        pendChk("cleared", 64'h0);
        end_of_test();
    end
endmodule
